// ---- logic/rssc_pkg.sv ----
// package for the reset source and start-up controller
// assumes one 25 MHz clock and an AXI4-Lite register slave
package rssc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int CLK_KHZ = 25000;
  localparam int POWER_UP_DELAY_TIMER_MS = 64;
  localparam int POWER_UP_DELAY_TIMER_CYC = POWER_UP_DELAY_TIMER_MS * CLK_KHZ;
  localparam int FILT_NS = 200;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CAUSE_A = 8'h00;
  localparam logic [7:0] OFF_CAUSE_B = 8'h04;
  localparam logic [7:0] OFF_CORE_STAT = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0c;
  localparam logic [7:0] OFF_PIN_CTRL = 8'h10;
  localparam logic [7:0] OFF_SEQ_STATE = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CA_STK_OVER = 7;
  localparam int CA_STK_UNDER = 6;
  localparam int CA_WIN_VIOL = 5;
  localparam int CA_WDT = 4;
  localparam int CA_PIN = 3;
  localparam int CA_OPCODE = 2;
  localparam int CA_POWER_ON = 1;
  localparam int CA_UNDERVOLT = 0;
  localparam int CB_FETCH = 1;
  localparam int CB_BATTERY = 0;
  localparam int CS_EXPIRY = 4;
  localparam int CS_SLEEP = 3;
  localparam int SEQ_GPIO_BIT = 8;

  // ----------------------------------------------------------------
  // reset and load values
  // ----------------------------------------------------------------
  localparam logic [7:0] CAUSE_A_POR = 8'h3c;
  localparam logic [7:0] CAUSE_A_UV = 8'h3c;
  localparam logic [7:0] CAUSE_A_UV_KEEP = 8'h02;
  localparam logic [1:0] CAUSE_B_POR = 2'h3;
  localparam logic [4:0] CORE_STAT_POR = 5'h18;
  localparam logic [6:0] CFG_ERASED = 7'h3e;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [14:0] PC_INT_VEC = 15'h0004;
  localparam logic [14:0] FLASH_TOP = 15'h2000;
  localparam logic [14:0] SAF_BASE = 15'h1f80;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic saf_en;
    logic ost_req;
    logic power_up_delay_enable_n_n;
    logic stack_fault_reset_enable;
    logic low_voltage_programming;
    logic pin_en;
    logic low_power_supply_monitor_en;
  } rssc_cfg_t;

  typedef enum logic [4:0] {
    S_UV = 5'h01,
    S_POWER_UP_DELAY_TIMER = 5'h02,
    S_OST = 5'h04,
    S_PIN = 5'h08,
    S_RUN = 5'h10
  } rssc_state_t;

endpackage

// ---- logic/rssc_top.sv ----
// reset source collection, cause flags and start-up sequencing
// assumes all inputs synchronous to CLK; RST is the power-on reset
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module rssc_top #(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = rssc_pkg::POWER_UP_DELAY_TIMER_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic UV_REQ,
  input wire logic LP_MON_REQ,
  input wire logic BAT_UV_REQ,
  input wire logic EXT_PIN_IN,
  input wire logic WDT_EXPIRE,
  input wire logic WDT_WIN_VIOL,
  input wire logic RESET_OPCODE,
  input wire logic STK_OVER,
  input wire logic STK_UNDER,
  input wire logic PROG_EXIT,
  input wire logic OST_DONE,
  input wire logic FETCH_EXEC,
  input wire logic [14:0] FETCH_ADDR,
  input wire logic WAKE_WDT,
  input wire logic WAKE_INT,
  input wire logic GLOBAL_INTERRUPT_ENABLE,
  input wire logic [14:0] CORE_PC,
  output logic CORE_RST,
  output logic PC_LOAD,
  output logic [14:0] PC_VALUE,
  output logic RET_PUSH,
  output logic EXT_PIN_OUT,
  output logic EXT_PIN_OE,
  output logic EXT_PIN_PULLUP,
  output logic EXT_PIN_GPIO,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  function automatic logic fetch_bad(input logic [14:0] a, input logic storage_area_flash);
    fetch_bad = (a >= rssc_pkg::FLASH_TOP) || (storage_area_flash && (a >= rssc_pkg::SAF_BASE));
  endfunction

  function automatic logic known_off(input logic [7:0] a);
    known_off = (a == rssc_pkg::OFF_CAUSE_A) || (a == rssc_pkg::OFF_CAUSE_B) ||
                (a == rssc_pkg::OFF_CORE_STAT) || (a == rssc_pkg::OFF_CONFIG) ||
                (a == rssc_pkg::OFF_PIN_CTRL) || (a == rssc_pkg::OFF_SEQ_STATE);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rssc_pkg::rssc_cfg_t cfg_reg;
  rssc_pkg::rssc_state_t state_reg, state_next;
  logic [7:0] cause_a_reg, cause_a_next;
  logic [1:0] cause_b_reg, cause_b_next;
  logic [4:0] stat_reg, stat_next;
  logic pullup_sw_reg;
  logic [20:0] power_up_delay_timer_cnt_reg;
  logic [2:0] filt_cnt_reg;
  logic pin_low_reg;
  logic vec_pend_reg;
  logic [7:0] aw_addr_reg;
  logic aw_have_reg;
  logic [7:0] w_data_reg;
  logic w_strb0_reg;
  logic w_have_reg;

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  wire logic uv_any = UV_REQ | (LP_MON_REQ & cfg_reg.low_power_supply_monitor_en);
  wire logic pin_fn_en = cfg_reg.pin_en | cfg_reg.low_voltage_programming;
  wire logic pin_hold = pin_fn_en & pin_low_reg;
  wire logic run = (state_reg == rssc_pkg::S_RUN);
  wire logic ev_wdt = run & WDT_EXPIRE;
  wire logic ev_wwv = run & WDT_WIN_VIOL;
  wire logic ev_ri = run & RESET_OPCODE;
  wire logic ev_ovf = run & STK_OVER & cfg_reg.stack_fault_reset_enable;
  wire logic ev_unf = run & STK_UNDER & cfg_reg.stack_fault_reset_enable;
  wire logic ev_fetch_violation_flag = run & FETCH_EXEC & fetch_bad(FETCH_ADDR, cfg_reg.saf_en);
  wire logic ev_pin = run & pin_hold;
  wire logic ev_bat = run & BAT_UV_REQ;
  wire logic int_rst = ev_wdt | ev_wwv | ev_ri | ev_ovf | ev_unf | ev_fetch_violation_flag | ev_bat;
  wire logic power_up_delay_timer_done = cfg_reg.power_up_delay_enable_n_n || (power_up_delay_timer_cnt_reg == 21'(POWER_UP_DELAY_TIMER_CYCLES - 1));
  wire logic start_exec = (state_reg == rssc_pkg::S_PIN) && (state_next == rssc_pkg::S_RUN);
  wire logic wake = run & (WAKE_WDT | WAKE_INT) & ~int_rst & ~pin_hold;

  // ----------------------------------------------------------------
  // pin glitch filter
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST || EXT_PIN_IN) begin
      filt_cnt_reg <= 3'h0;
      pin_low_reg <= 1'b0;
    end else if (filt_cnt_reg == 3'(rssc_pkg::FILT_CYC - 1)) begin
      pin_low_reg <= 1'b1;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (uv_any) begin
      state_next = rssc_pkg::S_UV;
    end else if (PROG_EXIT) begin
      state_next = rssc_pkg::S_POWER_UP_DELAY_TIMER;
    end else begin
      unique case (state_reg)
        rssc_pkg::S_UV: state_next = rssc_pkg::S_POWER_UP_DELAY_TIMER;
        rssc_pkg::S_POWER_UP_DELAY_TIMER: if (power_up_delay_timer_done) state_next = rssc_pkg::S_OST;
        rssc_pkg::S_OST: if (!cfg_reg.ost_req || OST_DONE) state_next = rssc_pkg::S_PIN;
        rssc_pkg::S_PIN: if (!pin_hold) state_next = rssc_pkg::S_RUN;
        rssc_pkg::S_RUN: if (int_rst || pin_hold) state_next = rssc_pkg::S_PIN;
        default: state_next = rssc_pkg::S_UV;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= rssc_pkg::S_POWER_UP_DELAY_TIMER;
      CORE_RST <= 1'b1;
    end else begin
      state_reg <= state_next;
      CORE_RST <= (state_next != rssc_pkg::S_RUN);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || state_reg != rssc_pkg::S_POWER_UP_DELAY_TIMER) begin
      power_up_delay_timer_cnt_reg <= 21'h0;
    end else if (!power_up_delay_timer_done) begin
      power_up_delay_timer_cnt_reg <= power_up_delay_timer_cnt_reg + 21'h1;
    end
  end

  // ----------------------------------------------------------------
  // program counter control
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      PC_LOAD <= 1'b0;
      PC_VALUE <= rssc_pkg::PC_RESET;
      RET_PUSH <= 1'b0;
      vec_pend_reg <= 1'b0;
    end else begin
      PC_LOAD <= start_exec | wake | (vec_pend_reg & run);
      RET_PUSH <= vec_pend_reg & run;
      vec_pend_reg <= wake & WAKE_INT & GLOBAL_INTERRUPT_ENABLE;
      if (start_exec) begin
        PC_VALUE <= rssc_pkg::PC_RESET;
      end else if (wake) begin
        PC_VALUE <= CORE_PC + 15'h1;
      end else if (vec_pend_reg) begin
        PC_VALUE <= rssc_pkg::PC_INT_VEC;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      EXT_PIN_OUT <= 1'b0;
      EXT_PIN_OE <= 1'b0;
      EXT_PIN_PULLUP <= 1'b1;
      EXT_PIN_GPIO <= 1'b0;
    end else begin
      EXT_PIN_OUT <= 1'b0;
      EXT_PIN_OE <= 1'b0;
      EXT_PIN_PULLUP <= pin_fn_en | pullup_sw_reg;
      EXT_PIN_GPIO <= ~pin_fn_en & EXT_PIN_IN;
    end
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  wire logic wr_fire = aw_have_reg & w_have_reg & ~S_AXI_BVALID;
  wire logic wr_ok = known_off(aw_addr_reg);
  wire logic wr_lane = wr_fire & w_strb0_reg;
  wire logic wr_ca = wr_lane && aw_addr_reg == rssc_pkg::OFF_CAUSE_A;
  wire logic wr_cb = wr_lane && aw_addr_reg == rssc_pkg::OFF_CAUSE_B;
  wire logic wr_cs = wr_lane && aw_addr_reg == rssc_pkg::OFF_CORE_STAT;
  wire logic wr_cfg = wr_lane && aw_addr_reg == rssc_pkg::OFF_CONFIG;
  wire logic wr_pc = wr_lane && aw_addr_reg == rssc_pkg::OFF_PIN_CTRL;
  wire logic [31:0] seq_word = {23'h0, EXT_PIN_GPIO, 3'h0, state_reg};
  wire logic [31:0] rd_word =
    (S_AXI_ARADDR == rssc_pkg::OFF_CAUSE_A) ? {24'h0, cause_a_reg} :
    (S_AXI_ARADDR == rssc_pkg::OFF_CAUSE_B) ? {30'h0, cause_b_reg} :
    (S_AXI_ARADDR == rssc_pkg::OFF_CORE_STAT) ? {27'h0, stat_reg} :
    (S_AXI_ARADDR == rssc_pkg::OFF_CONFIG) ? {25'h0, cfg_reg} :
    (S_AXI_ARADDR == rssc_pkg::OFF_PIN_CTRL) ? {31'h0, pullup_sw_reg} :
    (S_AXI_ARADDR == rssc_pkg::OFF_SEQ_STATE) ? seq_word : 32'h0;

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb0_reg <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= rssc_pkg::RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= ~aw_have_reg & ~(S_AXI_AWVALID & S_AXI_AWREADY);
      S_AXI_WREADY <= ~w_have_reg & ~(S_AXI_WVALID & S_AXI_WREADY);
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA[7:0];
        w_strb0_reg <= S_AXI_WSTRB[0];
      end
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? rssc_pkg::RESP_OKAY : rssc_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= rssc_pkg::RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_RVALID & ~(S_AXI_ARVALID & S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= known_off(S_AXI_ARADDR) ? rssc_pkg::RESP_OKAY : rssc_pkg::RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // cause flags: software write first, hardware event wins
  // ----------------------------------------------------------------
  always_comb begin
    cause_a_next = wr_ca ? w_data_reg : cause_a_reg;
    cause_b_next = wr_cb ? w_data_reg[1:0] : cause_b_reg;
    stat_next = wr_cs ? w_data_reg[4:0] : stat_reg;
    if (PROG_EXIT) begin
      cause_a_next = rssc_pkg::CAUSE_A_POR;
      cause_b_next = rssc_pkg::CAUSE_B_POR;
      stat_next = rssc_pkg::CORE_STAT_POR;
    end else if (uv_any) begin
      cause_a_next = rssc_pkg::CAUSE_A_UV | (cause_a_reg & rssc_pkg::CAUSE_A_UV_KEEP);
      stat_next = rssc_pkg::CORE_STAT_POR;
    end else begin
      if (ev_bat) begin
        cause_a_next = rssc_pkg::CAUSE_A_UV | (cause_a_reg & rssc_pkg::CAUSE_A_UV_KEEP);
        cause_b_next[rssc_pkg::CB_BATTERY] = 1'b0;
        stat_next = rssc_pkg::CORE_STAT_POR;
      end
      if (ev_wdt) begin
        cause_a_next[rssc_pkg::CA_WDT] = 1'b0;
        stat_next[rssc_pkg::CS_EXPIRY] = 1'b0;
      end
      if (ev_wwv) cause_a_next[rssc_pkg::CA_WIN_VIOL] = 1'b0;
      if (ev_ri) cause_a_next[rssc_pkg::CA_OPCODE] = 1'b0;
      if (ev_ovf) cause_a_next[rssc_pkg::CA_STK_OVER] = 1'b1;
      if (ev_unf) cause_a_next[rssc_pkg::CA_STK_UNDER] = 1'b1;
      if (ev_pin) cause_a_next[rssc_pkg::CA_PIN] = 1'b0;
      if (ev_fetch_violation_flag) cause_b_next[rssc_pkg::CB_FETCH] = 1'b0;
      if (wake) begin
        stat_next[rssc_pkg::CS_EXPIRY] = WAKE_INT;
        stat_next[rssc_pkg::CS_SLEEP] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cause_a_reg <= rssc_pkg::CAUSE_A_POR;
      cause_b_reg <= rssc_pkg::CAUSE_B_POR;
      stat_reg <= rssc_pkg::CORE_STAT_POR;
      cfg_reg <= rssc_pkg::CFG_ERASED;
      pullup_sw_reg <= 1'b1;
    end else begin
      cause_a_reg <= cause_a_next;
      cause_b_reg <= cause_b_next;
      stat_reg <= stat_next;
      if (wr_cfg) cfg_reg <= rssc_pkg::rssc_cfg_t'(w_data_reg[6:0]);
      if (wr_pc) pullup_sw_reg <= w_data_reg[0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  logic [20:0] power_up_delay_timer_seen_reg;
  always_ff @(posedge CLK) begin
    if (RST || state_reg != rssc_pkg::S_POWER_UP_DELAY_TIMER) power_up_delay_timer_seen_reg <= 21'h0;
    else power_up_delay_timer_seen_reg <= power_up_delay_timer_seen_reg + 21'h1;
  end

  chk_uv_holds: assert property (uv_any |=> CORE_RST && state_reg == rssc_pkg::S_UV &&
      !cause_a_reg[rssc_pkg::CA_UNDERVOLT]) else $error("undervoltage not held in reset");
  chk_lp_gated: assert property (LP_MON_REQ && !UV_REQ && !cfg_reg.low_power_supply_monitor_en &&
      state_reg == rssc_pkg::S_RUN && !PROG_EXIT |=> state_reg != rssc_pkg::S_UV)
    else $error("disabled low-power monitor caused reset");
  chk_pin_input: assert property (!EXT_PIN_OE) else $error("reset pin driven");
  // low pulse one sample shorter than the filter
  chk_pin_glitch: assert property ($fell(EXT_PIN_IN) ##1 !EXT_PIN_IN [*3] ##1
      EXT_PIN_IN |-> !pin_low_reg) else $error("short pulse accepted");
  chk_pin_hold: assert property (run && pin_hold && !uv_any && !PROG_EXIT |=>
      CORE_RST && !cause_a_reg[rssc_pkg::CA_PIN]) else $error("pin reset missed");
  chk_opcode_flag: assert property (ev_ri && !uv_any && !PROG_EXIT && !ev_bat && !wr_ca &&
      !ev_wdt && !ev_wwv && !ev_ovf && !ev_unf && !ev_pin |=>
      cause_a_reg == ($past(cause_a_reg) & 8'hfb)) else $error("opcode flag wrong");
  chk_stk_gated: assert property (run && STK_OVER && !cfg_reg.stack_fault_reset_enable && !uv_any &&
      !PROG_EXIT && !wr_ca |=> cause_a_reg[rssc_pkg::CA_STK_OVER] ==
      $past(cause_a_reg[rssc_pkg::CA_STK_OVER])) else $error("stack fault not gated");
  chk_fetch_viol: assert property (ev_fetch_violation_flag && !uv_any && !PROG_EXIT |=>
      !cause_b_reg[rssc_pkg::CB_FETCH] && CORE_RST) else $error("fetch violation missed");
  chk_power_up_delay_timer_len: assert property ($fell(state_reg == rssc_pkg::S_POWER_UP_DELAY_TIMER) &&
      !cfg_reg.power_up_delay_enable_n_n && !$past(uv_any) && !$past(PROG_EXIT) |->
      $past(power_up_delay_timer_seen_reg) == 21'(POWER_UP_DELAY_TIMER_CYCLES - 1)) else $error("power-up delay length");
  chk_start_pc: assert property ($fell(CORE_RST) |-> PC_LOAD &&
      PC_VALUE == rssc_pkg::PC_RESET) else $error("start pc not zero");
  chk_int_vec: assert property (wake && WAKE_INT && GLOBAL_INTERRUPT_ENABLE |=> PC_LOAD ##1
      RET_PUSH && PC_VALUE == rssc_pkg::PC_INT_VEC) else $error("interrupt vector wrong");

  cov_pin_reset: cover property (run && pin_hold ##[1:20] start_exec);
  cov_wdt_reset: cover property (ev_wdt ##[1:20] start_exec);
  cov_uv_cycle: cover property (uv_any ##1 !uv_any ##[1:50] state_reg == rssc_pkg::S_OST);
  cov_int_wake: cover property (wake && WAKE_INT && GLOBAL_INTERRUPT_ENABLE);

endmodule // rssc_top

// ---- testbench/rssc_core_model.sv ----
// partner model: core program counter, oscillator start-up and reset pin
// assumes the pin has a weak pull-up and the design never drives it
`timescale 1ns/1ps
module rssc_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic core_rst,
  input wire logic pc_load,
  input wire logic [14:0] pc_value,
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic hold_low,
  output logic pin_level,
  output logic ost_done,
  output logic [14:0] core_pc
);
  logic [2:0] ost_cnt;
  // when nobody drives the pin, hold_low pulls it low, otherwise the pull-up holds it high
  assign pin_level = pin_oe ? pin_out : ~hold_low;
  assign ost_done = ost_cnt == 3'h6;
  always_ff @(posedge clk) begin
    if (rst) begin
      ost_cnt <= 3'h0;
      core_pc <= 15'h0000;
    end else begin
      if (core_rst && ost_cnt != 3'h6) ost_cnt <= ost_cnt + 3'h1;
      if (pc_load) core_pc <= pc_value;
    end
  end
endmodule // rssc_core_model

// ---- testbench/testbench.sv ----
// testbench: reset sources, cause flags and start-up over the register bus
// assumes rssc_top with a short power-up delay and the core partner model
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst = 1, global_interrupt_enable = 0, wint = 0, windowed_watchdog = 0, awv = 0, wv = 0, arv = 0;
  logic [10:0] ev = '0;
  logic [14:0] fa = '0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wd = '0;
  wire logic crst, pld, rpush, poe, pout, pin, pup, gpio, ost, awr, wrr, bv, arr, rv;
  wire logic [14:0] pval, cpc;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdd;
  int mismatches = 0, cmp_count = 0, cyc = 0, n, b;
  initial forever #20 clk = ~clk;
  rssc_top #(.POWER_UP_DELAY_TIMER_CYCLES(20)) uut (.CLK(clk), .RST(rst), .UV_REQ(ev[0]), .LP_MON_REQ(ev[1]),
    .BAT_UV_REQ(ev[2]), .EXT_PIN_IN(pin), .WDT_EXPIRE(ev[3]), .WDT_WIN_VIOL(ev[4]),
    .RESET_OPCODE(ev[5]), .STK_OVER(ev[6]), .STK_UNDER(ev[7]), .PROG_EXIT(ev[8]),
    .OST_DONE(ost), .FETCH_EXEC(ev[9]), .FETCH_ADDR(fa), .WAKE_WDT(windowed_watchdog), .WAKE_INT(wint),
    .GLOBAL_INTERRUPT_ENABLE(global_interrupt_enable), .CORE_PC(cpc), .CORE_RST(crst), .PC_LOAD(pld), .PC_VALUE(pval),
    .RET_PUSH(rpush), .EXT_PIN_OUT(pout), .EXT_PIN_OE(poe), .EXT_PIN_PULLUP(pup),
    .EXT_PIN_GPIO(gpio), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdd), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1));
  rssc_core_model partner (.clk(clk), .rst(rst), .core_rst(crst), .pc_load(pld),
    .pc_value(pval), .pin_oe(poe), .pin_out(pout), .hold_low(ev[10]), .pin_level(pin),
    .ost_done(ost), .core_pc(cpc));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task conclude;
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er = rssc_pkg::RESP_OKAY);
    logic ta, tw, ah, wh;
    ah = 0;
    wh = 0;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1;
    while (!(ah && wh)) begin
      @(negedge clk); ta = awv & awr; tw = wv & wrr;
      @(posedge clk);
      if (ta) begin awv <= 0; ah = 1; end
      if (tw) begin wv <= 0; wh = 1; end
    end
    do @(negedge clk); while (bv !== 1'b1);
    chk({30'h0, br}, {30'h0, er});
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic t;
    @(posedge clk);
    ara <= a; arv <= 1;
    do begin @(negedge clk); t = arr; @(posedge clk); end while (!t);
    arv <= 0;
    do @(negedge clk); while (rv !== 1'b1);
    chk(rdd, e);
    chk({30'h0, rr}, {30'h0, er});
    @(posedge clk);
  endtask
  task run(output int c);
    c = 0;
    while (crst !== 1'b0) begin @(negedge clk); c++; end
    chk({16'h0, pld, pval}, {16'h0, 1'b1, rssc_pkg::PC_RESET});
  endtask
  // raise source b for k cycles, then see whether the core went into reset
  task fire(input int b, input int k, input logic x);
    logic s1, s2;
    @(posedge clk); ev <= 11'h1 << b;
    repeat (k) @(posedge clk);
    ev <= '0;
    @(negedge clk); s1 = crst;
    @(negedge clk); s2 = crst;
    chk({31'h0, s1 | s2}, {31'h0, x});
    if (x) run(n);
  endtask
  always @(negedge clk) if (!rst) chk({30'h0, poe, pout}, 32'h0);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin mismatches++; conclude; end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    run(n);
    rd(rssc_pkg::OFF_CAUSE_A, 32'h3c, rssc_pkg::RESP_OKAY);
    rd(rssc_pkg::OFF_CAUSE_B, 32'h3, rssc_pkg::RESP_OKAY);
    rd(rssc_pkg::OFF_CORE_STAT, 32'h18, rssc_pkg::RESP_OKAY);
    rd(rssc_pkg::OFF_CONFIG, 32'h3e, rssc_pkg::RESP_OKAY);
    rd(8'h40, 32'h0, rssc_pkg::RESP_SLVERR);
    wr(8'h40, 32'hff, rssc_pkg::RESP_SLVERR);
    fire(5, 1, 1);
    rd(rssc_pkg::OFF_CAUSE_A, 32'h38, rssc_pkg::RESP_OKAY);
    fire(3, 1, 1);
    rd(rssc_pkg::OFF_CAUSE_A, 32'h28, rssc_pkg::RESP_OKAY);
    rd(rssc_pkg::OFF_CORE_STAT, 32'h08, rssc_pkg::RESP_OKAY);
    fire(4, 1, 1);
    fire(6, 1, 1);
    rd(rssc_pkg::OFF_CAUSE_A, 32'h88, rssc_pkg::RESP_OKAY);
    wr(rssc_pkg::OFF_CONFIG, 32'h36);
    fire(7, 1, 0);
    fire(10, 4, 0);
    fire(10, 12, 1);
    rd(rssc_pkg::OFF_CAUSE_A, 32'h80, rssc_pkg::RESP_OKAY);
    wr(rssc_pkg::OFF_CAUSE_A, 32'hff);
    rd(rssc_pkg::OFF_CAUSE_A, 32'hff, rssc_pkg::RESP_OKAY);
    fire(1, 1, 0);
    wr(rssc_pkg::OFF_CONFIG, 32'h27);
    for (b = 0; b < 2; b++) begin
      fire(b, 1, 1);
      chk({31'h0, n >= 20}, 32'h1);
      rd(rssc_pkg::OFF_CAUSE_A, 32'h3e, rssc_pkg::RESP_OKAY);
    end
    rd(rssc_pkg::OFF_CORE_STAT, 32'h18, rssc_pkg::RESP_OKAY);
    fire(2, 1, 1);
    rd(rssc_pkg::OFF_CAUSE_B, 32'h2, rssc_pkg::RESP_OKAY);
    fa <= rssc_pkg::FLASH_TOP - 15'h1;
    fire(9, 1, 0);
    fa <= rssc_pkg::FLASH_TOP;
    fire(9, 1, 1);
    rd(rssc_pkg::OFF_CAUSE_B, 32'h0, rssc_pkg::RESP_OKAY);
    wr(rssc_pkg::OFF_CONFIG, 32'h67);
    wr(rssc_pkg::OFF_CAUSE_B, 32'h3);
    fa <= rssc_pkg::SAF_BASE;
    fire(9, 1, 1);
    rd(rssc_pkg::OFF_CAUSE_B, 32'h1, rssc_pkg::RESP_OKAY);
    @(posedge clk); wint <= 1; global_interrupt_enable <= 1;
    @(posedge clk); wint <= 0;
    @(negedge clk); chk({16'h0, pld, cpc + 15'h1}, {16'h0, 1'b1, pval});
    @(negedge clk); chk({15'h0, pld, rpush, pval}, {15'h0, 2'h3, rssc_pkg::PC_INT_VEC});
    rd(rssc_pkg::OFF_CORE_STAT, 32'h10, rssc_pkg::RESP_OKAY);
    @(posedge clk); windowed_watchdog <= 1;
    @(posedge clk); windowed_watchdog <= 0;
    @(negedge clk); chk({16'h0, pld, cpc + 15'h1}, {16'h0, 1'b1, pval});
    @(negedge clk); chk({30'h0, pld, rpush}, 32'h0);
    rd(rssc_pkg::OFF_CORE_STAT, 32'h00, rssc_pkg::RESP_OKAY);
    wr(rssc_pkg::OFF_CONFIG, 32'h20);
    wr(rssc_pkg::OFF_PIN_CTRL, 32'h0);
    @(posedge clk); ev <= 11'h400;
    repeat (10) @(posedge clk);
    @(negedge clk); chk({29'h0, crst, gpio, pup}, 32'h0);
    @(posedge clk); ev <= '0;
    rd(rssc_pkg::OFF_SEQ_STATE, 32'h110, rssc_pkg::RESP_OKAY);
    wr(rssc_pkg::OFF_CONFIG, 32'h24);
    fire(10, 12, 1);
    chk({31'h0, pup}, 32'h1);
    fire(8, 1, 1);
    rd(rssc_pkg::OFF_CAUSE_A, 32'h3c, rssc_pkg::RESP_OKAY);
    rd(rssc_pkg::OFF_CORE_STAT, 32'h18, rssc_pkg::RESP_OKAY);
    // pin held low through the whole power-up delay
    @(posedge clk); ev <= 11'h500;
    @(posedge clk); ev <= 11'h400;
    repeat (40) @(posedge clk);
    ev <= '0;
    run(n);
    chk({31'h0, n < 4}, 32'h1);
    conclude;
  end
endmodule // testbench
